/* File: adcmc_pkg.sv */
// constants and types shared by both ends of the converter control link
// Behaviour
// (RQ1) normal power after reset; low-power bit selects reduced mode
// (RQ2) power save command enters standby or sleep
// (RQ3) power save halts analog and filter processing
// (RQ4) standby keeps oscillator; run command returns promptly
// (RQ5) sleep stops oscillator; host waits for restart
// (RQ6) word-rate field selects rate; reset gives 15 Sps; here reset code 000 gives 64 oscillator ticks per word, about 512 Sps
// (RQ7) eight filters, one per rate code, settle once
// (RQ8) timing scales with master clock, external up to 100k
// (RQ9) reset-request bit starts reset cycle, sets valid flag
// (RQ10) reset loads config 000040, offset 0, gain 400000
// (RQ11) valid flag holds until config read; host clears request
// (RQ12) port flag chooses register read or null-then-24-bit read
// (RQ13) each calibration step one conversion, then clear, done
// (RQ14) code 011 runs offset then gain, done after gain
// (RQ15) data/offset/gain/setup reads clear done; config read not
// (RQ16) uncalibrated conversion uses gain 1.0 offset 0.0
// (RQ17) offset MSB is sign, LSB two to minus 24
// (RQ18) offset aligned to data by MSB; resets to zero
// (RQ19) port flag set: serial out low at calibration end
// (RQ20) power-up holds reset for 1002 oscillator cycles
// (RQ21) nonzero calibration code starts at next conversion boundary
package adcmc_pkg;
    localparam int          WORD_W        = 24;
    localparam logic [23:0] CFG_RESET     = 24'h000040;
    localparam logic [23:0] OFS_RESET     = 24'h000000;
    localparam logic [23:0] GAIN_RESET    = 24'h400000;
    localparam int          CFG_LPM_BIT   = 16;
    localparam int          CFG_WR_LSB    = 13;
    localparam int          CFG_PF_BIT    = 11;
    localparam int          CFG_RS_BIT    = 7;
    localparam int          CFG_CC_LSB    = 8;
    localparam int          CFG_PSS_BIT   = 4;
    localparam int          CFG_DF_BIT    = 2;
    localparam int          CFG_RV_BIT    = 6;
    localparam logic [7:0]  CMD_NULL      = 8'h00;
    localparam logic [7:0]  CMD_SAVE      = 8'h81;
    localparam logic [7:0]  CMD_RUN       = 8'h80;
    localparam logic [7:0]  CMD_CONV      = 8'hc0;
    localparam logic [7:0]  CMD_RW_BASE   = 8'h80;
    localparam logic [2:0]  RSEL_OFS      = 3'h0;
    localparam logic [2:0]  RSEL_GAIN     = 3'h1;
    localparam logic [2:0]  RSEL_CFG      = 3'h2;
    localparam logic [2:0]  RSEL_DATA     = 3'h3;
    localparam logic [2:0]  RSEL_SETUP    = 3'h4;
    localparam logic [2:0]  CC_OFS_GAIN   = 3'h3;
    localparam int          POR_CYCLES    = 1002;
    localparam int          RST_CYCLES    = 16;
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          LINK_HZ       = 200_000;
    localparam logic [7:0]  LINK_DIV      = 8'(CLK_HZ / LINK_HZ / 2);
    localparam int          XTAL_HZ_X1000 = 32768000;
    localparam int          OSC_DIV       = 1526;
    localparam logic [15:0] OWR_BASE      = 16'd64;
    typedef enum logic [1:0] {ADCMC_NORMAL, ADCMC_LOWPWR, ADCMC_STANDBY, ADCMC_SLEEP} adcmc_pwr_t;
endpackage : adcmc_pkg

/* File: adcmc_link_if.sv */
// serial command port between host controller and converter
`timescale 1ns/1ps
interface adcmc_link_if;
    logic sclk;
    logic sel_n;
    logic sdi;
    logic serial_data_out;
    logic sdo_oe;
    modport dev  (input sclk, input sel_n, input sdi, output serial_data_out, output sdo_oe);
    modport host (output sclk, output sel_n, output sdi, input serial_data_out, input sdo_oe);
endinterface : adcmc_link_if

/* File: adcmc_fifo.sv */
// small valid/ready word fifo
`timescale 1ns/1ps
module adcmc_fifo #(
    parameter int W = 24,
    parameter int D = 4
) (
    input  wire logic         sys_clk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    output logic [W-1:0]      out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0]   cnt_r;
    logic          push, pop;
    assign in_ready_out  = (cnt_r != (AW+1)'(D));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem[rp_r];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wp_r] <= in_data_in;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : adcmc_fifo

/* File: adcmc_dev.sv */
// converter end: command port, configuration, power, rate and calibration control
`timescale 1ns/1ps
module adcmc_dev (
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    adcmc_link_if.dev        link,
    input  wire logic [23:0] sample_in,
    output logic             osc_run_out,
    output logic             analog_on_out,
    output logic             low_power_out,
    output logic [2:0]       word_rate_out,
    output logic             conv_strobe_out,
    output logic [23:0]      result_out,
    output logic             in_reset_out
);
    // ***************************************
    // pin sampling
    // ***************************************
    logic [2:0] sclk_s_r, sel_s_r, sdi_s_r;
    logic       sclk_q_r, sel_q_r, sdi_q_r;
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sclk_s_r <= '0;
            sel_s_r  <= 3'h7;
            sdi_s_r  <= '0;
            sclk_q_r <= 1'b0;
            sel_q_r  <= 1'b1;
            sdi_q_r  <= 1'b0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], link.sclk};
            sel_s_r  <= {sel_s_r[1:0], link.sel_n};
            sdi_s_r  <= {sdi_s_r[1:0], link.sdi};
            if (sclk_s_r[1] == sclk_s_r[2]) sclk_q_r <= sclk_s_r[2];
            if (sel_s_r[1] == sel_s_r[2]) sel_q_r <= sel_s_r[2];
            if (sdi_s_r[1] == sdi_s_r[2]) sdi_q_r <= sdi_s_r[2];
        end
    end
    logic sclk_d_r;
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) sclk_d_r <= 1'b0;
        else sclk_d_r <= sclk_q_r;
    end
    wire rise = sclk_q_r && !sclk_d_r && !sel_q_r;
    wire fall = !sclk_q_r && sclk_d_r && !sel_q_r;

    // ***************************************
    // registers and state
    // ***************************************
    logic [23:0] cfg_r, ofs_r, gain_r, data_r, shin_r, shout_r;
    logic [6:0]  bitcnt_r;
    logic [6:0]  need_r;
    logic        incmd_r, rd_r, sdo_r, flag_r;
    logic [7:0]  cmd_r;
    logic [10:0] por_r;
    logic [10:0] osc_cnt_r;
    logic        osc_tick;
    logic [15:0] owr_cnt_r;
    logic [4:0]  rst_cnt_r;
    logic [1:0]  cal_step_r;
    logic        psave_r;
    adcmc_pkg::adcmc_pwr_t pwr_r;
    wire [2:0]   cc = cfg_r[adcmc_pkg::CFG_CC_LSB +: 3];
    wire         hold = (por_r != 11'd0) || cfg_r[adcmc_pkg::CFG_RS_BIT];
    function automatic logic [15:0] owr_period(input logic [2:0] wr);
        owr_period = adcmc_pkg::OWR_BASE << wr; // RQ7
    endfunction : owr_period

    // oscillator tick derived from system clock; stops in sleep
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) osc_cnt_r <= '0;
        else if (pwr_r == adcmc_pkg::ADCMC_SLEEP) osc_cnt_r <= '0; // RQ5
        else if (osc_cnt_r == 11'(adcmc_pkg::OSC_DIV - 1)) osc_cnt_r <= '0;
        else osc_cnt_r <= osc_cnt_r + 11'd1;
    end
    assign osc_tick = (osc_cnt_r == 11'(adcmc_pkg::OSC_DIV - 1)); // RQ8

    // power-up hold: loaded only by reset, not restarted after sleep
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) por_r <= 11'(adcmc_pkg::POR_CYCLES); // RQ20
        else if (osc_tick && por_r != 11'd0) por_r <= por_r - 11'd1;
    end

    // power mode
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pwr_r <= adcmc_pkg::ADCMC_NORMAL; // RQ1
        end else if (psave_r) begin
            pwr_r <= cfg_r[adcmc_pkg::CFG_PSS_BIT] ? adcmc_pkg::ADCMC_SLEEP : adcmc_pkg::ADCMC_STANDBY; // RQ2
        end else begin
            pwr_r <= cfg_r[adcmc_pkg::CFG_LPM_BIT] ? adcmc_pkg::ADCMC_LOWPWR : adcmc_pkg::ADCMC_NORMAL; // RQ1 RQ4
        end
    end
    wire running = (pwr_r == adcmc_pkg::ADCMC_NORMAL) || (pwr_r == adcmc_pkg::ADCMC_LOWPWR);

    // conversion timer
    wire conv_end = running && !hold && osc_tick && (owr_cnt_r == 16'd1);
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) owr_cnt_r <= owr_period(adcmc_pkg::CFG_RESET[adcmc_pkg::CFG_WR_LSB +: 3]);
        else if (!running) owr_cnt_r <= owr_cnt_r; // RQ3
        else if (osc_tick) begin
            if (owr_cnt_r <= 16'd1) owr_cnt_r <= owr_period(cfg_r[adcmc_pkg::CFG_WR_LSB +: 3]); // RQ6
            else owr_cnt_r <= owr_cnt_r - 16'd1;
        end
    end

    // software reset cycle
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) rst_cnt_r <= '0;
        else if (!cfg_r[adcmc_pkg::CFG_RS_BIT]) rst_cnt_r <= '0;
        else if (rst_cnt_r != 5'(adcmc_pkg::RST_CYCLES)) rst_cnt_r <= rst_cnt_r + 5'd1; // RQ9
    end
    wire rst_done = cfg_r[adcmc_pkg::CFG_RS_BIT] && rst_cnt_r == 5'(adcmc_pkg::RST_CYCLES - 1);

    // ***************************************
    // serial port
    // ***************************************
    wire [7:0] cmd_now = {shin_r[6:0], sdi_q_r};
    wire       last = rise && (bitcnt_r == need_r - 7'd1);
    logic      cfg_wr, rd_cfg, rd_clr, cal_fin;
    logic [23:0] cfg_wdata;
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || rst_done) begin // RQ9 RQ10
            incmd_r  <= 1'b1;
            bitcnt_r <= '0;
            need_r   <= 7'd8;
            shin_r   <= '0;
            cmd_r    <= adcmc_pkg::CMD_NULL;
            rd_r     <= 1'b0;
            psave_r  <= 1'b0;
        end else if (rise) begin
            shin_r <= {shin_r[22:0], sdi_q_r};
            if (!last) begin
                bitcnt_r <= bitcnt_r + 7'd1;
            end else if (incmd_r) begin
                bitcnt_r <= '0;
                cmd_r    <= cmd_now;
                if (cmd_now == adcmc_pkg::CMD_SAVE) psave_r <= 1'b1; // RQ2
                else if (cmd_now == adcmc_pkg::CMD_RUN) psave_r <= 1'b0; // RQ4
                if (cmd_now[7:5] == 3'b100 && cmd_now[0] == 1'b0) begin
                    incmd_r <= 1'b0;
                    rd_r    <= cmd_now[4];
                    need_r  <= (cmd_now[3:1] == adcmc_pkg::RSEL_SETUP) ? 7'd72 : 7'd24;
                end else if (cmd_now == adcmc_pkg::CMD_NULL && flag_r) begin
                    incmd_r <= 1'b0; // RQ12
                    rd_r    <= 1'b1;
                    need_r  <= 7'd24;
                end
            end else begin
                bitcnt_r <= '0;
                incmd_r  <= 1'b1;
                need_r   <= 7'd8;
            end
        end
    end
    wire [2:0] rsel = cmd_r[3:1];
    assign cfg_wr    = last && !incmd_r && !rd_r && (rsel == adcmc_pkg::RSEL_CFG || rsel == adcmc_pkg::RSEL_SETUP);
    assign cfg_wdata = {shin_r[22:0], sdi_q_r};
    // read access noticed at start of data phase
    wire   rd_start  = last && incmd_r && cmd_now[7:5] == 3'b100 && cmd_now[4] && !cmd_now[0];
    assign rd_cfg    = rd_start && (cmd_now[3:1] == adcmc_pkg::RSEL_CFG || cmd_now[3:1] == adcmc_pkg::RSEL_SETUP);
    assign rd_clr    = rd_start && cmd_now[3:1] != adcmc_pkg::RSEL_CFG; // RQ15

    // output shift: loaded at command end, moved on falling edges
    logic [71:0] out_sh_r;
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) out_sh_r <= '0;
        else if (rd_start) begin
            case (cmd_now[3:1])
                adcmc_pkg::RSEL_OFS:   out_sh_r <= {ofs_r, 48'h0};
                adcmc_pkg::RSEL_GAIN:  out_sh_r <= {gain_r, 48'h0};
                adcmc_pkg::RSEL_CFG:   out_sh_r <= {cfg_r, 48'h0};
                adcmc_pkg::RSEL_DATA:  out_sh_r <= {data_r, 48'h0};
                adcmc_pkg::RSEL_SETUP: out_sh_r <= {ofs_r, gain_r, cfg_r};
                default:               out_sh_r <= '0;
            endcase
        end else if (last && incmd_r && cmd_now == adcmc_pkg::CMD_NULL && flag_r) begin
            out_sh_r <= {data_r, 48'h0}; // RQ12
        // first fall after the command keeps the msb for the first data rise
        end else if (fall && !incmd_r && bitcnt_r != 7'd0) out_sh_r <= {out_sh_r[70:0], 1'b0};
    end

    // port flag: low on serial out while a result or calibration end is pending
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) flag_r <= 1'b0;
        else if (!cfg_r[adcmc_pkg::CFG_PF_BIT]) flag_r <= 1'b0;
        else if (conv_end) flag_r <= 1'b1; // RQ19
        else if (last && incmd_r && cmd_now == adcmc_pkg::CMD_NULL) flag_r <= 1'b0;
    end
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sdo_r       <= 1'b1;
            link.sdo_oe <= 1'b0;
        end else begin
            link.sdo_oe <= !sel_q_r;
            sdo_r <= (!incmd_r && rd_r) ? out_sh_r[71] : !flag_r; // RQ19
        end
    end
    assign link.serial_data_out = sdo_r;

    // ***************************************
    // configuration, calibration, conversion
    // ***************************************
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) cal_step_r <= '0;
        else if (conv_end && cc != 3'h0) begin // RQ21
            cal_step_r <= (cc == adcmc_pkg::CC_OFS_GAIN && cal_step_r == 2'd0) ? 2'd1 : 2'd2; // RQ14
        end else if (cal_step_r == 2'd2) cal_step_r <= 2'd0;
    end
    assign cal_fin = (cal_step_r == 2'd2);
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || rst_done) begin
            cfg_r <= adcmc_pkg::CFG_RESET; // RQ10
            if (rst_done) cfg_r[adcmc_pkg::CFG_RS_BIT] <= 1'b1;
            if (rst_done) cfg_r[adcmc_pkg::CFG_RV_BIT] <= 1'b1; // RQ9
        end else begin
            if (cfg_wr) begin
                cfg_r <= cfg_wdata;
                cfg_r[adcmc_pkg::CFG_DF_BIT] <= cfg_r[adcmc_pkg::CFG_DF_BIT];
                cfg_r[adcmc_pkg::CFG_RV_BIT] <= cfg_r[adcmc_pkg::CFG_RV_BIT];
            end
            if (rd_cfg) cfg_r[adcmc_pkg::CFG_RV_BIT] <= 1'b0; // RQ11
            if (rd_clr) cfg_r[adcmc_pkg::CFG_DF_BIT] <= 1'b0; // RQ15
            if (cal_fin) begin
                cfg_r[adcmc_pkg::CFG_CC_LSB +: 3] <= 3'h0; // RQ13
                cfg_r[adcmc_pkg::CFG_DF_BIT] <= 1'b1; // RQ13
            end
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || rst_done) begin
            ofs_r  <= adcmc_pkg::OFS_RESET; // RQ18
            gain_r <= adcmc_pkg::GAIN_RESET; // RQ16
        end else begin
            if (last && !incmd_r && !rd_r && rsel == adcmc_pkg::RSEL_OFS) ofs_r <= cfg_wdata;
            if (last && !incmd_r && !rd_r && rsel == adcmc_pkg::RSEL_GAIN) gain_r <= cfg_wdata;
            if (bitcnt_r == 7'd23 && rise && !incmd_r && !rd_r && rsel == adcmc_pkg::RSEL_SETUP) ofs_r <= cfg_wdata;
            if (bitcnt_r == 7'd47 && rise && !incmd_r && !rd_r && rsel == adcmc_pkg::RSEL_SETUP) gain_r <= cfg_wdata;
            if (conv_end && cc != 3'h0) begin
                if (cal_step_r == 2'd0 && cc != 3'h2) ofs_r <= 24'h0 - sample_in; // RQ17
                else gain_r <= adcmc_pkg::GAIN_RESET;
            end
        end
    end
    // corrected sample: signed offset by MSB, gain 2.22 fixed point
    logic [47:0] prod;
    logic [23:0] sum;
    always_comb begin
        sum  = sample_in + ofs_r; // RQ18
        prod = 48'(sum) * 48'(gain_r);
    end
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || rst_done) begin
            data_r          <= '0;
            conv_strobe_out <= 1'b0;
        end else begin
            conv_strobe_out <= conv_end && cc == 3'h0; // RQ21
            if (conv_end && cc == 3'h0) data_r <= prod[45:22]; // RQ16
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            osc_run_out   <= 1'b1;
            analog_on_out <= 1'b1;
            low_power_out <= 1'b0;
            word_rate_out <= adcmc_pkg::CFG_RESET[adcmc_pkg::CFG_WR_LSB +: 3];
            result_out    <= '0;
            in_reset_out  <= 1'b1;
        end else begin
            osc_run_out   <= pwr_r != adcmc_pkg::ADCMC_SLEEP;
            analog_on_out <= running; // RQ3
            low_power_out <= pwr_r == adcmc_pkg::ADCMC_LOWPWR;
            word_rate_out <= cfg_r[adcmc_pkg::CFG_WR_LSB +: 3];
            result_out    <= data_r;
            in_reset_out  <= hold;
        end
    end
endmodule : adcmc_dev

/* File: adcmc_host.sv */
// host end: sends command frames, collects read words through a fifo
`timescale 1ns/1ps
module adcmc_host (
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    adcmc_link_if.host       link,
    input  wire logic [7:0]  cmd_in,
    input  wire logic [23:0] wdata_in,
    input  wire logic [6:0]  nbits_in,
    input  wire logic        req_valid_in,
    output logic             req_ready_out,
    output logic [23:0]      rdata_out,
    output logic             rdata_valid_out,
    input  wire logic        rdata_ready_in,
    output logic             busy_out
);
    logic [2:0] sdo_s_r;
    logic       sdo_q_r;
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sdo_s_r <= 3'h7;
            sdo_q_r <= 1'b1;
        end else begin
            sdo_s_r <= {sdo_s_r[1:0], link.serial_data_out};
            if (sdo_s_r[1] == sdo_s_r[2]) sdo_q_r <= sdo_s_r[2];
        end
    end
    typedef enum logic [1:0] {ADCMC_IDLE, ADCMC_SHIFT, ADCMC_DONE} adcmc_hst_t;
    adcmc_hst_t  st_r;
    logic [7:0]  div_r;
    logic        sclk_r, sel_r, sdi_r, rd_r;
    logic [31:0] tx_r;
    logic [23:0] rx_r;
    logic [6:0]  cnt_r, nb_r;
    logic        push, fifo_rdy;
    wire         half = (div_r == adcmc_pkg::LINK_DIV - 8'h01);
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in || st_r != ADCMC_SHIFT) div_r <= '0;
        else if (half) div_r <= '0;
        else div_r <= div_r + 8'h01;
    end
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            st_r <= ADCMC_IDLE;
            sclk_r <= 1'b0;
            sel_r <= 1'b1;
            sdi_r <= 1'b0;
            tx_r <= '0;
            rx_r <= '0;
            cnt_r <= '0;
            nb_r <= '0;
            rd_r <= 1'b0;
            push <= 1'b0;
        end else begin
            push <= 1'b0;
            case (st_r)
                ADCMC_IDLE: begin
                    sel_r <= 1'b1;
                    if (req_valid_in && fifo_rdy) begin // RQ12
                        tx_r  <= {cmd_in, wdata_in};
                        nb_r  <= nbits_in + 7'd8;
                        cnt_r <= '0;
                        sel_r <= 1'b0;
                        sdi_r <= cmd_in[7];
                        rd_r  <= cmd_in[4] || (cmd_in == adcmc_pkg::CMD_NULL);
                        st_r  <= ADCMC_SHIFT;
                    end
                end
                ADCMC_SHIFT: begin
                    if (half) begin
                        sclk_r <= !sclk_r;
                        if (!sclk_r) begin
                            rx_r  <= {rx_r[22:0], sdo_q_r};
                            cnt_r <= cnt_r + 7'd1;
                        end else begin
                            tx_r  <= {tx_r[30:0], 1'b0};
                            sdi_r <= tx_r[30];
                            if (cnt_r == nb_r) st_r <= ADCMC_DONE;
                        end
                    end
                end
                ADCMC_DONE: begin
                    sel_r <= 1'b1;
                    push  <= (nb_r != 7'd8) && rd_r; // RQ11 RQ12
                    st_r  <= ADCMC_IDLE;
                end
                default: st_r <= ADCMC_IDLE;
            endcase
        end
    end
    assign link.sclk  = sclk_r;
    assign link.sel_n = sel_r;
    assign link.sdi   = sdi_r;
    assign req_ready_out = (st_r == ADCMC_IDLE) && fifo_rdy;
    assign busy_out      = (st_r != ADCMC_IDLE);
    adcmc_fifo #(.W(24), .D(4)) u_fifo (
        .sys_clk_in   (sys_clk_in),
        .resetn_in    (resetn_in),
        .in_data_in   (rx_r),
        .in_valid_in  (push),
        .in_ready_out (fifo_rdy),
        .out_data_out (rdata_out),
        .out_valid_out(rdata_valid_out),
        .out_ready_in (rdata_ready_in)
    );
endmodule : adcmc_host

/* File: adcmc_link_monitor.sv */
// wire checks on the link joining host and converter ends
`timescale 1ns/1ps
module adcmc_link_monitor (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic sdi,
    input wire logic serial_data_out,
    input wire logic sdo_oe
);
    logic        sclk_r;
    logic [7:0]  hcnt_r;
    logic [6:0]  rise_r;
    logic [15:0] fcnt_r;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // ************************************************
    // phase, bit and frame counters
    // ************************************************
    always_ff @(posedge sys_clk_in) begin
        sclk_r <= resetn_in ? sclk : 1'b0;
        hcnt_r <= (!resetn_in || sclk != sclk_r) ? 8'h01 : hcnt_r + {7'h00, hcnt_r != 8'hff};
    end
    always_ff @(posedge sys_clk_in) begin
        rise_r <= (!resetn_in || sel_n) ? 7'h00 : rise_r + {6'h00, sclk && !sclk_r};
        fcnt_r <= (!resetn_in || sel_n) ? 16'h0000 : fcnt_r + 16'h0001;
    end
    AST_IDLE_LOW: assert property (sel_n |-> !sclk) else $error("link clock high while deselected");
    AST_OE_RELEASE: assert property (sel_n [*6] |-> !sdo_oe) else $error("data out driven while deselected");
    AST_HIGH_PHASE: assert property ($fell(sclk) |-> hcnt_r == 8'h7d) else $error("link clock high phase wrong");
    AST_SDI_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdi)) else $error("data in moved while clock high");
    AST_BIT_COUNT: assert property ($rose(sel_n) |-> rise_r inside {7'h08, 7'h20, 7'h50}) else $error("frame bit count wrong");
    AST_LEAD_IN: assert property ($fell(sel_n) |-> !sclk [*8]) else $error("no low lead-in after select");
    AST_SEL_HOLD: assert property ($rose(sclk) |-> !sel_n [*8]) else $error("select dropped during a bit");
    AST_FRAME_LEN: assert property (!sel_n |-> fcnt_r < 16'h5014) else $error("frame runs too long");
    COV_CMD: cover property ($rose(sel_n) && rise_r == 7'h08);
    COV_WORD: cover property ($rose(sel_n) && rise_r == 7'h20);
    COV_DRIVE: cover property ($rose(sdo_oe) ##1 (serial_data_out || !serial_data_out));
endmodule : adcmc_link_monitor

/* File: adc_mode_reset_calibration_control_tb.sv */
// self-checking bench: host and converter ends joined over the link
`timescale 1ns/1ps
module adc_mode_reset_calibration_control_tb;
    typedef struct packed {logic [7:0] cmd; logic [23:0] wd; logic [6:0] nb; logic ana;} adcmc_row_t;
    logic        sys_clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [7:0]  cmd_in = 8'h00;
    logic [23:0] wdata_in = 24'h000000;
    logic [6:0]  nbits_in = 7'h00;
    logic        req_valid_in = 1'b0;
    logic        rdata_ready_in = 1'b0;
    logic        req_ready_out, rdata_valid_out, busy_out, in_reset_out, low_power_out;
    logic        osc_run_out, analog_on_out;
    logic [23:0] rdata_out;
    logic [2:0]  word_rate_out;
    logic [31:0] cap;
    logic [6:0]  nrise;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    adcmc_row_t  rows [4] = '{'{8'h81, 24'h000000, 7'h00, 1'b0}, '{8'h80, 24'h000000, 7'h18, 1'b1},
                              '{8'h82, 24'h400000, 7'h18, 1'b1}, '{8'h84, 24'h000040, 7'h18, 1'b1}};
    adcmc_link_if link();
    adcmc_dev adcmc_dev_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link),
        .sample_in(24'h000000), .osc_run_out(osc_run_out), .analog_on_out(analog_on_out),
        .low_power_out(low_power_out),
        .word_rate_out(word_rate_out), .conv_strobe_out(), .result_out(), .in_reset_out(in_reset_out));
    adcmc_host adcmc_host_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link), .cmd_in(cmd_in),
        .wdata_in(wdata_in), .nbits_in(nbits_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out), .rdata_ready_in(rdata_ready_in),
        .busy_out(busy_out));
    adcmc_link_monitor adcmc_link_monitor_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sclk(link.sclk),
        .sel_n(link.sel_n), .sdi(link.sdi), .serial_data_out(link.serial_data_out), .sdo_oe(link.sdo_oe));
    always #10 sys_clk_in = ~sys_clk_in;
    // ************************************************
    // wire capture, timeout and shared tasks
    // ************************************************
    always @(posedge link.sclk) begin
        if (!link.sel_n) begin
            cap <= {cap[30:0], link.sdi};
            nrise <= nrise + 7'h01;
        end
    end
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask : check
    task automatic frame(input adcmc_row_t r);
        logic rd;
        rd = r.cmd[4];
        cap = 32'h0;
        nrise = 7'h00;
        @(posedge sys_clk_in);
        cmd_in <= r.cmd;
        wdata_in <= r.wd;
        nbits_in <= r.nb;
        req_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        while (req_ready_out !== 1'b1) @(posedge sys_clk_in);
        req_valid_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        while (busy_out !== 1'b0) @(posedge sys_clk_in);
        check("bits", {25'h0, nrise}, {25'h0, r.nb + 7'h08});
        check("frame", (r.nb == 0) ? {24'h0, cap[7:0]} : {cap[31:24], rd ? 24'h0 : cap[23:0]},
              (r.nb == 0) ? {24'h0, r.cmd} : {r.cmd, rd ? 24'h0 : r.wd});
        check("analog", {31'h0, analog_on_out}, {31'h0, r.ana});
        check("osc", {31'h0, osc_run_out}, 32'h1);
    endtask : frame
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (2) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        @(posedge sys_clk_in);
        check("hold", {31'h0, in_reset_out}, 32'h1);
        check("lowpwr", {31'h0, low_power_out}, 32'h0);
        check("rate", {29'h0, word_rate_out}, {29'h0, adcmc_pkg::CFG_RESET[adcmc_pkg::CFG_WR_LSB +: 3]});
        foreach (rows[i]) frame(rows[i]);
        for (int i = 0; i < 4; i++) frame('{8'h94, 24'h000000, 7'h18, 1'b1});
        @(posedge sys_clk_in);
        req_valid_in <= 1'b1;
        repeat (20) @(posedge sys_clk_in);
        check("refuse", {31'h0, req_ready_out}, 32'h0);
        req_valid_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            check("fill", {31'h0, rdata_valid_out}, 32'h1);
            check("rdata", {8'h0, rdata_out},
                  {8'h0, adcmc_pkg::CFG_RESET} & ~(32'(i > 0) << adcmc_pkg::CFG_RV_BIT));
            rdata_ready_in <= 1'b1;
            @(posedge sys_clk_in);
            rdata_ready_in <= 1'b0;
            @(posedge sys_clk_in);
        end
        repeat (2) @(posedge sys_clk_in);
        check("empty", {31'h0, rdata_valid_out}, 32'h0);
        frame('{8'h84, 24'h000080, 7'h18, 1'b1});
        frame('{8'h94, 24'h000000, 7'h18, 1'b1});
        repeat (2) @(posedge sys_clk_in);
        check("rst", {8'h0, rdata_out}, {8'h0, adcmc_pkg::CFG_RESET} | (32'h1 << adcmc_pkg::CFG_RS_BIT)
              | (32'h1 << adcmc_pkg::CFG_RV_BIT));
        check("still", {31'h0, in_reset_out}, 32'h1);
        wrap_up();
    end
endmodule : adc_mode_reset_calibration_control_tb
